/* File: include/capture_pkg.sv */
// Constants, state type and helpers of the segmented waveform capture block.
// Assumes one 200 MHz sampling timebase and control bits on plain ports.
// Function
// - All enabled converters write memory in lockstep from one timebase.
// - Every accepted trigger gets a time stamp spanning at least 213 days.
// - Single capture is segmented capture with count one; count defaults to one.
// - Segmented capture splits memory into 2 to 1000 equal segments; with optional memory the count is not capped and can reach 1023.
// - Each segment needs its own trigger; segments fill in trigger order.
// - After a segment ends, rearm well inside 350 ns.
// - Overlapped readout fills 2 to 1000 circular banks in rotation.
// - Host reads a filled bank while device never writes that bank.
// - Overlapped bank readout only with internal memory.
// - Measure trigger to first sample delay in 10 ps steps, keep it.
// - Channel combining interleaves two or four converters onto one input.
// - Trigger stops acquisition by default; optional mode starts it instead.
// - Trigger source is a channel, external input or star line.
// - High bandwidth front ends forbid channel trigger sources.
// - Positive slope fires rising through level, negative slope falling.
// - Captured span is points in use times the sample interval.
// - Optional memory starts each segment on a 2K page; stamps kept aside.
package capture_pkg;
  localparam int NUM_CH = 4;
  localparam int SAMPLE_W = 16;
  localparam int MEM_AW = 14;
  localparam int PT_W = 14;
  localparam int SEG_W = 10;
  // 2^52 cycles of 5 ns exceed 213 days
  localparam int STAMP_W = 52;
  localparam int FINE_W = 9;
  localparam int CLK_PS = 5000;
  localparam int FINE_PS = 10;
  localparam logic [FINE_W-1:0] FINE_STEPS = FINE_W'(CLK_PS / FINE_PS);
  localparam int DEAD_LIMIT_NS = 350;
  localparam int DEAD_LIMIT_CYC = DEAD_LIMIT_NS * 1000 / CLK_PS;
  localparam logic [1:0] DEAD_CYC = 2'h2;
  localparam int PAGE_AW = 11;
  localparam logic [SEG_W-1:0] SEG_MAX_BASE = 10'h3e8;
  localparam logic [SEG_W-1:0] SEG_ONE = 10'h001;
  localparam logic [PT_W-1:0] PT_ONE = 14'h0001;
  localparam int STAMP_WORD_W = PT_W + FINE_W + STAMP_W;
  localparam logic [2:0] SRC_EXT = 3'h4;
  localparam logic [2:0] SRC_STAR = 3'h5;
  localparam logic [1:0] COMB_TWO = 2'h1;
  localparam logic [1:0] COMB_FOUR = 2'h2;

  typedef enum logic [2:0] {
    st_idle, st_prefill, st_armed, st_capture, st_dead, st_hold, st_done
  } capture_state_t;

  function automatic logic [PT_W-1:0] eff_words(input logic [PT_W-1:0] w);
    eff_words = (w == '0) ? PT_ONE : w;
  endfunction

  function automatic logic [SEG_W-1:0] eff_count(input logic [SEG_W-1:0] c,
                                                 input logic ext);
    if (c == '0)
      eff_count = SEG_ONE;
    else if (!ext && c > SEG_MAX_BASE)
      eff_count = SEG_MAX_BASE;
    else
      eff_count = c;
  endfunction

  function automatic logic [MEM_AW-1:0] seg_stride(input logic [PT_W-1:0] w,
                                                   input logic ext);
    logic [MEM_AW-1:0] r;
    r = MEM_AW'(eff_words(w));
    if (ext && r[PAGE_AW-1:0] != '0)
      r = ((r >> PAGE_AW) + MEM_AW'(1)) << PAGE_AW;
    seg_stride = r;
  endfunction

  function automatic logic [PT_W+1:0] span_of(input logic [PT_W-1:0] w,
                                              input logic [1:0] comb);
    logic [PT_W+1:0] s;
    s = (PT_W + 2)'(eff_words(w));
    if (comb == COMB_TWO)
      s = s << 1;
    else if (comb == COMB_FOUR)
      s = s << 2;
    span_of = s;
  endfunction
endpackage

/* File: hdl/capture_ram.sv */
// Simple dual port memory with a registered read port.
// Assumes one clock; a read of the word being written returns old data.
`timescale 1ns/10ps
`default_nettype none
module capture_ram #(
  parameter int W = 64,
  parameter int AW = 14
) (
  // Clock
  input wire logic clk,
  // Write side
  input wire logic we,
  input wire logic [AW-1:0] waddr,
  input wire logic [W-1:0] wdata,
  // Read side
  input wire logic re,
  input wire logic [AW-1:0] raddr,
  output logic [W-1:0] rdata
);
  logic [W-1:0] mem [0:(1<<AW)-1];

  always_ff @(posedge clk)
  begin
    if (we)
      mem[waddr] <= wdata;
  end

  always_ff @(posedge clk)
  begin
    if (re)
      rdata <= mem[raddr];
  end
endmodule
`default_nettype wire

/* File: hdl/segmented_waveform_capture.sv */
// Acquisition memory control: single, segmented and overlapped bank capture.
// Assumes converter words arrive every ref_clk cycle and trigger comparators
// and the phase interpolator come in from pins asynchronously.
`timescale 1ns/10ps
`default_nettype none
module segmented_waveform_capture (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic reset,
  // Converter streams
  input wire logic [capture_pkg::NUM_CH*capture_pkg::SAMPLE_W-1:0] adc_data,
  // Trigger pins
  input wire logic [capture_pkg::NUM_CH-1:0] ch_trig_lvl,
  input wire logic ext_trig_lvl,
  input wire logic star_trig_lvl,
  input wire logic [capture_pkg::FINE_W-1:0] trig_phase,
  // Acquisition setup
  input wire logic arm,
  input wire logic [capture_pkg::SEG_W-1:0] seg_count,
  input wire logic [capture_pkg::PT_W-1:0] seg_words,
  input wire logic start_on_trig,
  input wire logic [2:0] trig_src,
  input wire logic slope_neg,
  input wire logic [1:0] comb_mode,
  input wire logic hf_frontend,
  input wire logic ext_mem_sel,
  input wire logic overlapped_bank_readout,
  // Host readout
  input wire logic sample_rd_en,
  input wire logic [capture_pkg::MEM_AW-1:0] sample_rd_addr,
  input wire logic stamp_rd_en,
  input wire logic [capture_pkg::SEG_W-1:0] stamp_rd_addr,
  input wire logic bank_release,
  // Status and read data
  output wire logic [capture_pkg::NUM_CH*capture_pkg::SAMPLE_W-1:0] sample_rd_data,
  output wire logic [capture_pkg::STAMP_WORD_W-1:0] stamp_rd_data,
  output logic armed,
  output logic acq_done,
  output logic [capture_pkg::SEG_W-1:0] seg_index,
  output logic [capture_pkg::SEG_W-1:0] read_bank,
  output logic [capture_pkg::SEG_W-1:0] banks_filled,
  output logic [capture_pkg::PT_W+1:0] span_points
);
  import capture_pkg::*;

  localparam int NUM_LVL = NUM_CH + 2;

  logic [NUM_LVL-1:0] lvl_s1, lvl_s2, lvl_s3, lvl;
  logic [FINE_W-1:0] ph_s1, ph_s2, ph_s3, phase;
  logic sel_lvl, sel_prev, src_ok, trig_edge, trig_acc;
  logic [SEG_W-1:0] cfg_count;
  logic [PT_W-1:0] cfg_words;
  logic [MEM_AW-1:0] cfg_stride;
  logic [2:0] cfg_src;
  logic cfg_start, cfg_neg, cfg_bank, cfg_ext;
  capture_state_t state, next_state, rearm_state, after_seg;
  logic [PT_W-1:0] wr_off;
  logic [MEM_AW-1:0] seg_base, mem_waddr;
  logic [1:0] dead_cnt;
  logic last_seg, seg_end, mem_we, bank_full, rel_ok;
  logic [SEG_W-1:0] next_filled;
  logic [STAMP_W-1:0] stamp_cnt;
  logic stamp_we;
  logic [SEG_W-1:0] stamp_waddr;
  logic [STAMP_WORD_W-1:0] stamp_wdata;

  // ****************************************
  // Pin synchronisers
  // ****************************************
  always_ff @(posedge ref_clk)
  begin
    if (reset)
    begin
      lvl_s1 <= '0;
      lvl_s2 <= '0;
      lvl_s3 <= '0;
      ph_s1 <= '0;
      ph_s2 <= '0;
      ph_s3 <= '0;
    end
    else
    begin
      lvl_s1 <= {star_trig_lvl, ext_trig_lvl, ch_trig_lvl};
      lvl_s2 <= lvl_s1;
      lvl_s3 <= lvl_s2;
      ph_s1 <= trig_phase;
      ph_s2 <= ph_s1;
      ph_s3 <= ph_s2;
    end
  end

  // A bit only moves once two late stages agree
  always_ff @(posedge ref_clk)
  begin
    if (reset)
    begin
      lvl <= '0;
      phase <= '0;
    end
    else
    begin
      lvl <= ((lvl_s2 ~^ lvl_s3) & lvl_s3) | ((lvl_s2 ^ lvl_s3) & lvl);
      if (ph_s2 == ph_s3)
        phase <= ph_s3;
    end
  end

  // ****************************************
  // Trigger source and slope
  // ****************************************
  always_comb
  begin
    sel_lvl = 1'b0;
    src_ok = 1'b0;
    if (cfg_src == SRC_EXT)
    begin
      sel_lvl = lvl[NUM_CH];
      src_ok = 1'b1;
    end
    else if (cfg_src == SRC_STAR)
    begin
      sel_lvl = lvl[NUM_CH+1];
      src_ok = 1'b1;
    end
    else if (cfg_src < SRC_EXT)
    begin
      sel_lvl = lvl[cfg_src[1:0]];
      src_ok = !hf_frontend;
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (reset)
      sel_prev <= 1'b0;
    else
      sel_prev <= sel_lvl;
  end

  assign trig_edge = (sel_lvl != sel_prev) && (sel_lvl == !cfg_neg);
  assign trig_acc = (state == st_armed) && trig_edge && src_ok;

  // ****************************************
  // Configuration latched at arm
  // ****************************************
  // Held for the whole run so a live edit cannot tear a segment layout
  always_ff @(posedge ref_clk)
  begin
    if (reset)
    begin
      cfg_count <= SEG_ONE;
      cfg_words <= PT_ONE;
      cfg_stride <= MEM_AW'(PT_ONE);
      cfg_src <= SRC_EXT;
      cfg_start <= 1'b0;
      cfg_neg <= 1'b0;
      cfg_bank <= 1'b0;
      cfg_ext <= 1'b0;
    end
    else if (arm)
    begin
      cfg_count <= eff_count(seg_count, ext_mem_sel);
      cfg_words <= eff_words(seg_words);
      cfg_stride <= seg_stride(seg_words, ext_mem_sel);
      cfg_src <= trig_src;
      cfg_start <= start_on_trig;
      cfg_neg <= slope_neg;
      cfg_bank <= overlapped_bank_readout && !ext_mem_sel;
      cfg_ext <= ext_mem_sel;
    end
  end

  // ****************************************
  // Capture sequencing
  // ****************************************
  assign last_seg = (seg_index == cfg_count - SEG_ONE);
  assign bank_full = cfg_bank && (banks_filled == cfg_count);
  assign rearm_state = cfg_start ? st_armed : st_prefill;
  assign after_seg = (last_seg && !cfg_bank) ? st_done : st_dead;
  assign seg_end = (trig_acc && !cfg_start) ||
                   (state == st_capture && wr_off == cfg_words - PT_ONE);
  assign mem_we = (state == st_prefill) || (state == st_capture) ||
                  (state == st_armed && !cfg_start);
  assign mem_waddr = seg_base + MEM_AW'(wr_off);

  always_comb
  begin
    next_state = state;
    if (arm)
      next_state = start_on_trig ? st_armed : st_prefill;
    else
    begin
      unique case (state)
        st_idle: next_state = st_idle;
        st_prefill:
          if (wr_off == cfg_words - PT_ONE)
            next_state = st_armed;
        st_armed:
          if (trig_acc)
            next_state = cfg_start ? st_capture : after_seg;
        st_capture:
          if (seg_end)
            next_state = after_seg;
        st_dead:
          if (dead_cnt == '0)
            next_state = bank_full ? st_hold : rearm_state;
        st_hold:
          if (!bank_full)
            next_state = rearm_state;
        st_done: next_state = st_done;
      endcase
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (reset)
      state <= st_idle;
    else
      state <= next_state;
  end

  always_ff @(posedge ref_clk)
  begin
    if (reset || seg_end)
      dead_cnt <= DEAD_CYC - 2'h1;
    else if (state == st_dead && dead_cnt != '0)
      dead_cnt <= dead_cnt - 2'h1;
  end

  // Stop mode wraps inside the segment until a trigger lands
  always_ff @(posedge ref_clk)
  begin
    if (reset || arm || seg_end || trig_acc)
      wr_off <= '0;
    else if (mem_we)
      wr_off <= (wr_off == cfg_words - PT_ONE) ? '0 : wr_off + PT_ONE;
  end

  always_ff @(posedge ref_clk)
  begin
    if (reset || arm)
    begin
      seg_index <= '0;
      seg_base <= '0;
    end
    else if (seg_end)
    begin
      seg_index <= last_seg ? '0 : seg_index + SEG_ONE;
      seg_base <= last_seg ? '0 : seg_base + cfg_stride;
    end
  end

  // ****************************************
  // Bank bookkeeping and status
  // ****************************************
  assign rel_ok = cfg_bank && bank_release && (banks_filled != '0);

  always_comb
  begin
    next_filled = banks_filled;
    if (cfg_bank && seg_end && !rel_ok)
      next_filled = banks_filled + SEG_ONE;
    else if (rel_ok && !(cfg_bank && seg_end))
      next_filled = banks_filled - SEG_ONE;
  end

  always_ff @(posedge ref_clk)
  begin
    if (reset || arm)
    begin
      banks_filled <= '0;
      read_bank <= '0;
    end
    else
    begin
      banks_filled <= next_filled;
      if (rel_ok)
        read_bank <= (read_bank == cfg_count - SEG_ONE) ? '0 : read_bank + SEG_ONE;
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (reset || arm)
      acq_done <= 1'b0;
    else if (cfg_bank)
      acq_done <= (next_filled == cfg_count);
    else
      acq_done <= (next_state == st_done);
  end

  always_ff @(posedge ref_clk)
  begin
    if (reset)
      armed <= 1'b0;
    else
      armed <= (next_state == st_armed);
  end

  always_ff @(posedge ref_clk)
  begin
    if (reset)
      span_points <= '0;
    else
      span_points <= span_of(seg_words, comb_mode);
  end

  // ****************************************
  // Time stamps and fine delay
  // ****************************************
  // wide free running stamp
  always_ff @(posedge ref_clk)
  begin
    if (reset)
      stamp_cnt <= '0;
    else
      stamp_cnt <= stamp_cnt + STAMP_W'(1);
  end

  always_ff @(posedge ref_clk)
  begin
    if (reset)
    begin
      stamp_we <= 1'b0;
      stamp_waddr <= '0;
      stamp_wdata <= '0;
    end
    else
    begin
      stamp_we <= trig_acc;
      stamp_waddr <= seg_index;
      stamp_wdata <= {wr_off, FINE_STEPS - phase, stamp_cnt};
    end
  end

  // ****************************************
  // Memories
  // ****************************************
  capture_ram #(
    .W(NUM_CH * SAMPLE_W),
    .AW(MEM_AW)
  ) u_sample_ram (
    .clk(ref_clk),
    .we(mem_we),
    .waddr(mem_waddr),
    .wdata(adc_data),
    .re(sample_rd_en),
    .raddr(sample_rd_addr),
    .rdata(sample_rd_data)
  );

  capture_ram #(
    .W(STAMP_WORD_W),
    .AW(SEG_W)
  ) u_stamp_ram (
    .clk(ref_clk),
    .we(stamp_we),
    .waddr(stamp_waddr),
    .wdata(stamp_wdata),
    .re(stamp_rd_en),
    .raddr(stamp_rd_addr),
    .rdata(stamp_rd_data)
  );

  // ****************************************
  // Assertions
  // ****************************************
  localparam int REARM_MAX = DEAD_LIMIT_CYC;

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (reset);

  property p_lockstep;
    mem_we |-> !(state inside {st_idle, st_dead, st_hold, st_done});
  endproperty
  a_lockstep: assert property (p_lockstep) else $error("write outside capture");

  property p_stamp;
    trig_acc |=> stamp_we && stamp_wdata[STAMP_W-1:0] == $past(stamp_cnt);
  endproperty
  a_stamp: assert property (p_stamp) else $error("stamp not taken");

  property p_single;
    (trig_acc && !cfg_start && !cfg_bank && cfg_count == SEG_ONE)
      |=> state == st_done && acq_done;
  endproperty
  a_single: assert property (p_single) else $error("single run not done");

  property p_order;
    (seg_end && !last_seg) |=> seg_index == $past(seg_index) + SEG_ONE;
  endproperty
  a_order: assert property (p_order) else $error("segment out of order");

  property p_rearm;
    (state == st_dead && !bank_full) |-> ##[1:REARM_MAX] state != st_dead;
  endproperty
  a_rearm: assert property (p_rearm) else $error("rearm too slow");

  property p_bank_hold;
    bank_full |-> !mem_we;
  endproperty
  a_bank_hold: assert property (p_bank_hold) else $error("wrote a full bank");

  property p_no_ext_bank;
    (cfg_ext && seg_end && last_seg) |=> state == st_done;
  endproperty
  a_no_ext_bank: assert property (p_no_ext_bank) else $error("banks on ext mem");

  property p_fine;
    trig_acc |=> stamp_wdata[STAMP_W+FINE_W-1:STAMP_W] == FINE_STEPS - $past(phase);
  endproperty
  a_fine: assert property (p_fine) else $error("fine delay wrong");

  property p_start;
    (trig_acc && cfg_start) |=> state == st_capture && wr_off == '0;
  endproperty
  a_start: assert property (p_start) else $error("start mode failed");

  property p_hf;
    (hf_frontend && cfg_src < SRC_EXT) |-> !trig_acc;
  endproperty
  a_hf: assert property (p_hf) else $error("channel trigger on hf");

  property p_slope;
    trig_acc |-> $past(sel_lvl) != sel_lvl && sel_lvl == !cfg_neg;
  endproperty
  a_slope: assert property (p_slope) else $error("wrong slope");

  property p_page;
    (mem_we && cfg_ext && wr_off == '0 && state != st_armed)
      |-> mem_waddr[PAGE_AW-1:0] == '0;
  endproperty
  a_page: assert property (p_page) else $error("segment off page");

  c_single_done: cover property (trig_acc ##1 state == st_done);
  c_bank_hold: cover property (state == st_hold ##[1:50] state != st_hold);
  c_start_capture: cover property (trig_acc && cfg_start);
endmodule
`default_nettype wire

/* File: dv/capture_host_model.sv */
// Host side model: reads sample and stamp memory and releases banks.
// Assumes registered read data one cycle after the enable edge.
`timescale 1ns/10ps
`default_nettype none
module capture_host_model (
  // Clock
  input wire logic ref_clk,
  // Read requests
  output logic sample_rd_en,
  output logic [capture_pkg::MEM_AW-1:0] sample_rd_addr,
  output logic stamp_rd_en,
  output logic [capture_pkg::SEG_W-1:0] stamp_rd_addr,
  output logic bank_release,
  // Read data
  input wire logic [capture_pkg::NUM_CH*capture_pkg::SAMPLE_W-1:0] sample_rd_data,
  input wire logic [capture_pkg::STAMP_WORD_W-1:0] stamp_rd_data
);
  import capture_pkg::*;
  initial
  begin
    sample_rd_en = 1'b0;
    sample_rd_addr = '0;
    stamp_rd_en = 1'b0;
    stamp_rd_addr = '0;
    bank_release = 1'b0;
  end
  // Released address is inverted so no stale value lingers
  task automatic read_sample(input logic [MEM_AW-1:0] a, output logic [NUM_CH*SAMPLE_W-1:0] d);
    @(posedge ref_clk);
    sample_rd_en <= 1'b1;
    sample_rd_addr <= a;
    @(posedge ref_clk);
    sample_rd_en <= 1'b0;
    sample_rd_addr <= ~a;
    #1;
    d = sample_rd_data;
  endtask
  task automatic read_stamp(input logic [SEG_W-1:0] a, output logic [STAMP_WORD_W-1:0] d);
    @(posedge ref_clk);
    stamp_rd_en <= 1'b1;
    stamp_rd_addr <= a;
    @(posedge ref_clk);
    stamp_rd_en <= 1'b0;
    stamp_rd_addr <= ~a;
    #1;
    d = stamp_rd_data;
  endtask
  task automatic release_bank;
    @(posedge ref_clk);
    bank_release <= 1'b1;
    @(posedge ref_clk);
    bank_release <= 1'b0;
  endtask
endmodule
`default_nettype wire

/* File: dv/segmented_waveform_capture_tb_top.sv */
// Self-checking bench of the segmented waveform capture block.
// Assumes the host model and the capture package are compiled first.
`timescale 1ns/10ps
`default_nettype none
module segmented_waveform_capture_tb_top;
  import capture_pkg::*;
  logic ref_clk = 1'b0;
  logic reset = 1'b1;
  logic [NUM_CH*SAMPLE_W-1:0] adc_data = '0;
  logic [15:0] cnt = '0;
  logic tl = 1'b0;
  logic [NUM_CH+1:0] pins;
  // Only the selected source toggles, so a wrong source select shows up
  always_comb
  begin
    for (int k = 0; k < NUM_CH + 2; k++)
      pins[k] = (trig_src == 3'(k)) ? tl : slope_neg;
  end
  logic [FINE_W-1:0] trig_phase = '0;
  logic arm = 1'b0;
  logic [SEG_W-1:0] seg_count = '0;
  logic [PT_W-1:0] seg_words = '0;
  logic start_on_trig = 1'b0;
  logic [2:0] trig_src = '0;
  logic slope_neg = 1'b0;
  logic [1:0] comb_mode = '0;
  logic hf_frontend = 1'b0;
  logic ext_mem_sel = 1'b0;
  logic bank_mode = 1'b0;
  logic sample_rd_en, stamp_rd_en, bank_release, armed, acq_done;
  logic [MEM_AW-1:0] sample_rd_addr;
  logic [SEG_W-1:0] stamp_rd_addr, seg_index, read_bank, banks_filled;
  logic [NUM_CH*SAMPLE_W-1:0] sample_rd_data;
  logic [STAMP_WORD_W-1:0] stamp_rd_data;
  logic [PT_W+1:0] span_points;
  int n_mismatch = 0;
  int compares = 0;

  always #2.5 ref_clk = ~ref_clk;
  // Lanes differ by a fixed offset so a torn word shows up
  always @(posedge ref_clk)
  begin
    cnt <= cnt + 16'h0001;
    adc_data <= {cnt + 16'h0003, cnt + 16'h0002, cnt + 16'h0001, cnt};
  end

  segmented_waveform_capture DUT (
    .ref_clk(ref_clk), .reset(reset), .adc_data(adc_data),
    .ch_trig_lvl(pins[NUM_CH-1:0]), .ext_trig_lvl(pins[NUM_CH]),
    .star_trig_lvl(pins[NUM_CH+1]),
    .trig_phase(trig_phase), .arm(arm), .seg_count(seg_count), .seg_words(seg_words),
    .start_on_trig(start_on_trig), .trig_src(trig_src), .slope_neg(slope_neg),
    .comb_mode(comb_mode), .hf_frontend(hf_frontend), .ext_mem_sel(ext_mem_sel),
    .overlapped_bank_readout(bank_mode), .sample_rd_en(sample_rd_en),
    .sample_rd_addr(sample_rd_addr), .stamp_rd_en(stamp_rd_en),
    .stamp_rd_addr(stamp_rd_addr), .bank_release(bank_release),
    .sample_rd_data(sample_rd_data), .stamp_rd_data(stamp_rd_data), .armed(armed),
    .acq_done(acq_done), .seg_index(seg_index), .read_bank(read_bank),
    .banks_filled(banks_filled), .span_points(span_points));

  capture_host_model HOST (
    .ref_clk(ref_clk), .sample_rd_en(sample_rd_en), .sample_rd_addr(sample_rd_addr),
    .stamp_rd_en(stamp_rd_en), .stamp_rd_addr(stamp_rd_addr),
    .bank_release(bank_release), .sample_rd_data(sample_rd_data),
    .stamp_rd_data(stamp_rd_data));

  // ******************************
  // Checking and run control
  // ******************************
  task automatic chk(input logic [79:0] seen, input logic [79:0] exp);
    compares++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task final_report;
    if (n_mismatch == 0 && compares > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  function automatic logic cond(input int s);
    cond = (s == 0) ? armed : acq_done;
  endfunction
  task automatic wait_until(input int s, input int lim);
    int i;
    i = 0;
    while (cond(s) !== 1'b1)
    begin
      @(posedge ref_clk);
      #1;
      i++;
      if (i > lim)
      begin
        n_mismatch++;
        final_report;
      end
    end
  endtask
  // Setup latched at the arm edge; idle pin level follows slope
  task automatic start(input logic [SEG_W-1:0] c, input logic sot, input logic neg,
                       input logic bk, input logic em, input logic [2:0] src);
    @(posedge ref_clk);
    seg_count <= c;
    seg_words <= 14'h0004;
    start_on_trig <= sot;
    slope_neg <= neg;
    bank_mode <= bk;
    ext_mem_sel <= em;
    trig_src <= src;
    tl <= neg;
    arm <= 1'b1;
    @(posedge ref_clk);
    arm <= 1'b0;
    #1;
  endtask
  task automatic pulse(input logic [FINE_W-1:0] ph);
    @(posedge ref_clk);
    tl <= !slope_neg;
    trig_phase <= ph;
    repeat (8) @(posedge ref_clk);
    tl <= slope_neg;
    repeat (8) @(posedge ref_clk);
    #1;
  endtask

  // ******************************
  // Scenarios
  // ******************************
  task automatic t_span;
    for (int m = 0; m < 3; m++)
    begin
      @(posedge ref_clk);
      seg_words <= 14'h0005;
      comb_mode <= 2'(m);
      repeat (2) @(posedge ref_clk);
      #1;
      chk(span_points, 16'h0005 << m);
    end
    @(posedge ref_clk);
    seg_words <= '0;
    comb_mode <= '0;
    repeat (2) @(posedge ref_clk);
    #1;
    chk(span_points, 16'h0001);
  endtask
  // Stop mode, count 0 reads as one, every source code
  task automatic t_sources;
    for (int s = 0; s < 9; s++)
    begin
      @(posedge ref_clk);
      hf_frontend <= (s == 8);
      start(10'h000, 1'b0, 1'b0, 1'b0, 1'b0, 3'(s % 8));
      wait_until(0, 40);
      chk(acq_done, 1'b0);
      pulse(9'h000);
      chk(acq_done, s < 6);
    end
    @(posedge ref_clk);
    hf_frontend <= 1'b0;
  endtask
  task automatic t_seq;
    logic [STAMP_WORD_W-1:0] s [3];
    logic [NUM_CH*SAMPLE_W-1:0] d;
    start(10'h003, 1'b1, 1'b1, 1'b0, 1'b0, SRC_STAR);
    for (int i = 0; i < 3; i++)
    begin
      wait_until(0, 40);
      chk(seg_index, i);
      pulse(9'(40 * i + 7));
      chk(armed, i < 2);
    end
    chk(acq_done, 1'b1);
    for (int i = 0; i < 3; i++)
      HOST.read_stamp(10'(i), s[i]);
    for (int i = 0; i < 3; i++)
      chk(s[i][60:52], FINE_STEPS - 9'(40 * i + 7));
    chk(s[1][51:0] > s[0][51:0], 1'b1);
    chk(s[2][51:0] > s[1][51:0], 1'b1);
    HOST.read_sample(14'h0001, d);
    chk(d[31:16] - d[15:0], 16'h0001);
    chk(d[63:48] - d[15:0], 16'h0003);
  endtask
  task automatic t_bank(input logic em);
    logic [NUM_CH*SAMPLE_W-1:0] d;
    start(10'h002, 1'b1, 1'b0, 1'b1, em, SRC_EXT);
    for (int i = 0; i < 2; i++)
    begin
      wait_until(0, 40);
      pulse(9'h010);
    end
    wait_until(1, 40);
    chk(banks_filled, em ? 10'h000 : 10'h002);
    if (!em)
    begin
      pulse(9'h010);
      chk(banks_filled, 10'h002);
      chk(read_bank, 10'h000);
      HOST.read_sample(14'h0000, d);
      chk(d[47:32] - d[15:0], 16'h0002);
      HOST.release_bank;
      repeat (2) @(posedge ref_clk);
      #1;
      chk(banks_filled, 10'h001);
      chk(read_bank, 10'h001);
      chk(acq_done, 1'b0);
    end
  endtask

  initial
  begin
    repeat (16) @(posedge ref_clk);
    #1;
    chk({armed, acq_done, banks_filled, span_points}, '0);
    @(posedge ref_clk);
    reset <= 1'b0;
    t_span;
    t_sources;
    t_seq;
    t_bank(1'b0);
    t_bank(1'b1);
    final_report;
  end
  // Whole-run guard against a hang
  initial
  begin
    repeat (60000) @(posedge ref_clk);
    n_mismatch++;
    final_report;
  end
endmodule
`default_nettype wire
